//--- bsr_pkg.sv
// Overview of operation
// - Keep host and guest copies; route each reference by current mode.
// - Selection covers explicit moves and implicit use at exception entry.
// - In Host mode guest copies never affect CPU behaviour.
// - In Guest mode host copies never affect CPU behaviour.
// - Host mode reaches each guest copy at its own alternate number.
// - Guest mode offers no number reaching any host copy.
// - Original register number and host copy share one storage.
// - Group-0 guest copies sit at same index in group 9.
// - Group-1, 2, 5 guest copies map one-to-one into group 9.
// - Host-handled interrupt or fault in Guest mode switches to Host mode.
package bsr_pkg;

	localparam int NREG = 20;
	localparam logic [4:0] ALT_GROUP = 5'h09;

	typedef struct packed {
		logic [4:0] idx;
		logic [4:0] grp;
	} bsr_regnum_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		bsr_regnum_s num;
		logic [31:0] wdata;
	} bsr_access_s;

	// Original numbers, slot order shared with the alternate table
	localparam bsr_regnum_s ORIG_NUM [NREG] = '{
		'{5'h00, 5'h00}, '{5'h01, 5'h00}, '{5'h02, 5'h00}, '{5'h03, 5'h00},
		'{5'h05, 5'h00}, '{5'h0d, 5'h00}, '{5'h0e, 5'h00}, '{5'h1c, 5'h00},
		'{5'h1d, 5'h00}, '{5'h00, 5'h01}, '{5'h01, 5'h01}, '{5'h03, 5'h01},
		'{5'h04, 5'h01}, '{5'h08, 5'h01}, '{5'h00, 5'h02}, '{5'h06, 5'h02},
		'{5'h08, 5'h02}, '{5'h0d, 5'h02}, '{5'h0e, 5'h02}, '{5'h00, 5'h05}
	};

	// Indices within the alternate group for each guest copy
	localparam logic [4:0] ALT_IDX [NREG] = '{
		5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h0d, 5'h0e, 5'h1c, 5'h1d,
		5'h10, 5'h11, 5'h13, 5'h14, 5'h18, 5'h1e, 5'h06, 5'h08, 5'h15,
		5'h16, 5'h19
	};

	localparam int SLOT_PSW     = 4;
	localparam int SLOT_EIPC    = 0;
	localparam int SLOT_EIPSW   = 1;
	localparam int SLOT_EIIC    = 5;
	localparam int SLOT_FEPC    = 2;
	localparam int SLOT_FEPSW   = 3;
	localparam int SLOT_FEIC    = 6;
	localparam int SLOT_EBASE   = 11;

	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

endpackage

//--- bsr_decode.sv
`timescale 1ns/1ps
// Maps a register number to a slot and copy
module bsr_decode (
	// Request
	input  wire logic                guest_mode,
	input  wire bsr_pkg::bsr_regnum_s num,
	// Result
	output logic                     hit,
	output logic                     to_guest,
	output logic [4:0]               slot
);
	always_comb begin
		hit = 1'b0;
		to_guest = 1'b0;
		slot = 5'h00;
		for (int i = 0; i < bsr_pkg::NREG; i++) begin
			if (num == bsr_pkg::ORIG_NUM[i]) begin
				hit = 1'b1;
				to_guest = guest_mode;
				slot = 5'(i);
			end
			if (!guest_mode && num.grp == bsr_pkg::ALT_GROUP &&
				num.idx == bsr_pkg::ALT_IDX[i]) begin
				hit = 1'b1;
				to_guest = 1'b1;
				slot = 5'(i);
			end
		end
	end
endmodule

//--- bsr_copy.sv
`timescale 1ns/1ps
// One 32-bit storage word
module bsr_copy (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Write port
	input  wire logic        we,
	input  wire logic [31:0] wdata,
	// Value
	output logic [31:0]      value_q
);
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			value_q <= bsr_pkg::RESET_VALUE;
		end else if (we) begin
			value_q <= wdata;
		end
	end
endmodule

//--- bsr_mux.sv
`timescale 1ns/1ps
// Banked exception-related system registers, host and guest copies
module bsr_mux (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                resetn,
	// Mode control
	input  wire logic                guest_mode_set,
	input  wire logic                host_return_to_guest,
	output logic                     guest_mode_q,
	// Move instructions
	input  wire bsr_pkg::bsr_access_s move_req,
	output logic                     move_hit,
	output logic [31:0]              move_rdata_q,
	output logic                     move_err_q,
	// Exception entry
	input  wire logic                external_int_request,
	input  wire logic                int_host_handled,
	input  wire logic                prot_fault,
	input  wire logic                guest_handling_config,
	input  wire logic                ei_take,
	input  wire logic [31:0]         ei_pc,
	input  wire logic [31:0]         ei_cause,
	input  wire logic                fe_take,
	input  wire logic [31:0]         fe_pc,
	input  wire logic [31:0]         fe_cause,
	input  wire logic [31:0]         new_psw,
	// Active views for execution
	output logic [31:0]              act_psw,
	output logic [31:0]              act_ebase,
	output logic                     to_host_q
);
	localparam int N = bsr_pkg::NREG;

	logic [31:0] host_v [N];
	logic [31:0] guest_v [N];
	logic [N-1:0] host_we;
	logic [N-1:0] guest_we;
	logic [31:0] host_wd [N];
	logic [31:0] guest_wd [N];
	logic        dec_guest;
	logic [4:0]  dec_slot;
	logic        go_host;
	logic        impl_guest;

	bsr_decode u_dec (
		.guest_mode (guest_mode_q),
		.num        (move_req.num),
		.hit        (move_hit),
		.to_guest   (dec_guest),
		.slot       (dec_slot)
	);

	assign go_host = guest_mode_q &&
		((external_int_request && int_host_handled && ei_take) ||
		 (prot_fault && !guest_handling_config && fe_take));

	// Implicit saves land in the host copy on a switch to Host mode, else in the copy of the current mode
	// Implicit use follows mode
	assign impl_guest = guest_mode_q && !go_host;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			guest_mode_q <= 1'b0;
		end else if (go_host) begin
			guest_mode_q <= 1'b0;
		end else if (host_return_to_guest || guest_mode_set) begin
			guest_mode_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			to_host_q <= 1'b0;
		end else begin
			to_host_q <= go_host;
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			host_we[i] = 1'b0;
			guest_we[i] = 1'b0;
			host_wd[i] = move_req.wdata;
			guest_wd[i] = move_req.wdata;
		end
		if (move_req.valid && move_req.write && move_hit) begin
			if (dec_guest) begin
				guest_we[dec_slot] = 1'b1;
			end else begin
				host_we[dec_slot] = 1'b1;
			end
		end
		// Exception entry saves override a coincident move
		if (ei_take) begin
			if (impl_guest) begin
				guest_we[bsr_pkg::SLOT_EIPC] = 1'b1;
				guest_wd[bsr_pkg::SLOT_EIPC] = ei_pc;
				guest_we[bsr_pkg::SLOT_EIPSW] = 1'b1;
				guest_wd[bsr_pkg::SLOT_EIPSW] = guest_v[bsr_pkg::SLOT_PSW];
				guest_we[bsr_pkg::SLOT_EIIC] = 1'b1;
				guest_wd[bsr_pkg::SLOT_EIIC] = ei_cause;
				guest_we[bsr_pkg::SLOT_PSW] = 1'b1;
				guest_wd[bsr_pkg::SLOT_PSW] = new_psw;
			end else begin
				host_we[bsr_pkg::SLOT_EIPC] = 1'b1;
				host_wd[bsr_pkg::SLOT_EIPC] = ei_pc;
				host_we[bsr_pkg::SLOT_EIPSW] = 1'b1;
				host_wd[bsr_pkg::SLOT_EIPSW] = guest_mode_q ?
					guest_v[bsr_pkg::SLOT_PSW] : host_v[bsr_pkg::SLOT_PSW];
				host_we[bsr_pkg::SLOT_EIIC] = 1'b1;
				host_wd[bsr_pkg::SLOT_EIIC] = ei_cause;
				host_we[bsr_pkg::SLOT_PSW] = 1'b1;
				host_wd[bsr_pkg::SLOT_PSW] = new_psw;
			end
		end else if (fe_take) begin
			if (impl_guest) begin
				guest_we[bsr_pkg::SLOT_FEPC] = 1'b1;
				guest_wd[bsr_pkg::SLOT_FEPC] = fe_pc;
				guest_we[bsr_pkg::SLOT_FEPSW] = 1'b1;
				guest_wd[bsr_pkg::SLOT_FEPSW] = guest_v[bsr_pkg::SLOT_PSW];
				guest_we[bsr_pkg::SLOT_FEIC] = 1'b1;
				guest_wd[bsr_pkg::SLOT_FEIC] = fe_cause;
				guest_we[bsr_pkg::SLOT_PSW] = 1'b1;
				guest_wd[bsr_pkg::SLOT_PSW] = new_psw;
			end else begin
				host_we[bsr_pkg::SLOT_FEPC] = 1'b1;
				host_wd[bsr_pkg::SLOT_FEPC] = fe_pc;
				host_we[bsr_pkg::SLOT_FEPSW] = 1'b1;
				host_wd[bsr_pkg::SLOT_FEPSW] = guest_mode_q ?
					guest_v[bsr_pkg::SLOT_PSW] : host_v[bsr_pkg::SLOT_PSW];
				host_we[bsr_pkg::SLOT_FEIC] = 1'b1;
				host_wd[bsr_pkg::SLOT_FEIC] = fe_cause;
				host_we[bsr_pkg::SLOT_PSW] = 1'b1;
				host_wd[bsr_pkg::SLOT_PSW] = new_psw;
			end
		end
	end

	// Two banks; the original is the host copy itself
	for (genvar g = 0; g < N; g++) begin : g_bank
		bsr_copy u_host (
			.core_clk (core_clk),
			.resetn   (resetn),
			.we       (host_we[g]),
			.wdata    (host_wd[g]),
			.value_q  (host_v[g])
		);
		bsr_copy u_guest (
			.core_clk (core_clk),
			.resetn   (resetn),
			.we       (guest_we[g]),
			.wdata    (guest_wd[g]),
			.value_q  (guest_v[g])
		);
	end

	// Only the active bank drives execution
	assign act_psw = guest_mode_q ? guest_v[bsr_pkg::SLOT_PSW]
		: host_v[bsr_pkg::SLOT_PSW];
	assign act_ebase = guest_mode_q ? guest_v[bsr_pkg::SLOT_EBASE]
		: host_v[bsr_pkg::SLOT_EBASE];

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			move_rdata_q <= 32'h0000_0000;
			move_err_q <= 1'b0;
		end else if (move_req.valid) begin
			move_err_q <= !move_hit;
			if (!move_req.write && move_hit) begin
				move_rdata_q <= dec_guest ? guest_v[dec_slot] : host_v[dec_slot];
			end
		end else begin
			move_err_q <= 1'b0;
		end
	end

endmodule

//--- bsr_mux_monitor.sv
`timescale 1ns/1ps
module bsr_mux_monitor (
	// Clock and reset
	input wire logic                 core_clk,
	input wire logic                 resetn,
	// Mode
	input wire logic                 guest_mode_set,
	input wire logic                 host_return_to_guest,
	input wire logic                 guest_mode_q,
	input wire logic                 to_host_q,
	// Moves
	input wire bsr_pkg::bsr_access_s move_req,
	input wire logic                 move_hit,
	input wire logic                 move_err_q,
	input wire logic [31:0]          act_psw,
	// Exceptions
	input wire logic                 external_int_request,
	input wire logic                 int_host_handled,
	input wire logic                 prot_fault,
	input wire logic                 guest_handling_config,
	input wire logic                 ei_take,
	input wire logic                 fe_take
);
	logic quiet;
	logic wr;
	assign quiet = !ei_take && !fe_take && !guest_mode_set
		&& !host_return_to_guest;
	assign wr = move_req.valid && move_req.write && quiet;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	chk_err_decode: assert property (
		move_req.valid |=> move_err_q == !$past(move_hit))
		else $error("error flag mismatch");
	chk_guest_blind: assert property (
		guest_mode_q && move_req.valid && move_req.num.grp == 5'h09
		|-> !move_hit) else $error("host copy reachable");
	chk_alt_decode: assert property (
		!guest_mode_q && move_req.valid && move_req.num.grp == 5'h09
		&& move_req.num.idx inside {[5'h00:5'h03], 5'h05, 5'h06, 5'h08,
		[5'h0d:5'h0e], [5'h10:5'h11], [5'h13:5'h16], [5'h18:5'h19],
		[5'h1c:5'h1e]} |-> move_hit) else $error("alternate missed");
	chk_ei_host: assert property (
		guest_mode_q && ei_take && external_int_request && int_host_handled
		&& !guest_mode_set |=> !guest_mode_q && to_host_q)
		else $error("interrupt kept guest mode");
	chk_fe_host: assert property (
		guest_mode_q && fe_take && !ei_take && prot_fault
		&& !guest_handling_config && !guest_mode_set
		|=> to_host_q ##1 !to_host_q) else $error("fault kept guest mode");
	chk_fe_guest: assert property (
		guest_mode_q && fe_take && !ei_take && guest_handling_config
		|=> guest_mode_q && !to_host_q) else $error("fault left guest");
	chk_host_stays: assert property (
		!guest_mode_q && !guest_mode_set && !host_return_to_guest
		|=> !guest_mode_q) else $error("mode left host");
	chk_guest_hidden: assert property (
		!guest_mode_q && wr && move_req.num == {5'h05, 5'h09}
		|=> $stable(act_psw)) else $error("guest copy leaked");
	chk_psw_write: assert property (
		wr && move_req.num == {5'h05, 5'h00}
		|=> act_psw == $past(move_req.wdata)) else $error("psw write lost");
endmodule
bind bsr_mux bsr_mux_monitor u_bsr_mux_monitor (.*);

//--- bsr_cpu_model.sv
`timescale 1ns/1ps
module bsr_cpu_model (
	// Clock and reset
	input wire logic   core_clk,
	input wire logic   resetn,
	// 1 prompt interrupt, 2 slow host fault, 3 slower guest fault
	input wire logic [1:0]  kind,
	input wire logic [31:0] pc,
	// Exception side
	output logic        external_int_request,
	output logic        int_host_handled,
	output logic        prot_fault,
	output logic        guest_handling_config,
	output logic        ei_take,
	output logic        fe_take,
	output logic [31:0] epc,
	output logic [31:0] ecause,
	output logic [31:0] npsw
);
	logic [1:0] kind_q;
	logic [1:0] cnt_q;
	assign epc = pc;
	assign ecause = {16'h0000, pc[15:0]};
	assign npsw = ~pc;
	assign external_int_request = (kind_q == 2'h1);
	assign int_host_handled = (kind_q == 2'h1);
	assign prot_fault = kind_q[1];
	assign guest_handling_config = (kind_q == 2'h3);
	assign ei_take = (kind_q == 2'h1) && (cnt_q == 2'h0);
	assign fe_take = kind_q[1] && (cnt_q == 2'h0);
	always @(negedge core_clk) begin
		if (!resetn || kind_q == 2'h0) begin
			kind_q <= resetn ? kind : 2'h0;
			cnt_q <= kind - 2'h1;
		end else if (cnt_q != 2'h0) begin
			cnt_q <= cnt_q - 2'h1;
		end else begin
			kind_q <= 2'h0;
		end
	end
endmodule

//--- tb_bsr_mux.sv
`timescale 1ns/1ps
module tb_bsr_mux;
	logic                 core_clk, resetn, guest_mode_set, host_return_to_guest;
	bsr_pkg::bsr_access_s move_req;
	logic [1:0]           kind;
	logic [31:0]          pc, seed, epc, ecause, npsw, act_psw, act_ebase;
	logic [31:0]          ev [2][bsr_pkg::NREG];
	logic                 guest_mode_q, move_hit, move_err_q, to_host_q;
	logic [31:0]          move_rdata_q;
	logic                 eir, ihh, pf, ghc, ei_take, fe_take, b;
	int                   error_cnt, tests_run, sp;
	bsr_cpu_model u_bsr_cpu_model (.core_clk(core_clk), .resetn(resetn),
		.kind(kind), .pc(pc), .external_int_request(eir),
		.int_host_handled(ihh), .prot_fault(pf), .guest_handling_config(ghc),
		.ei_take(ei_take), .fe_take(fe_take), .epc(epc), .ecause(ecause),
		.npsw(npsw));
	bsr_mux u_bsr_mux (.core_clk(core_clk), .resetn(resetn),
		.guest_mode_set(guest_mode_set), .guest_mode_q(guest_mode_q),
		.host_return_to_guest(host_return_to_guest), .move_req(move_req),
		.move_hit(move_hit), .move_rdata_q(move_rdata_q),
		.move_err_q(move_err_q), .external_int_request(eir),
		.int_host_handled(ihh), .prot_fault(pf), .guest_handling_config(ghc),
		.ei_take(ei_take), .ei_pc(epc), .ei_cause(ecause), .fe_take(fe_take),
		.fe_pc(epc), .fe_cause(ecause), .new_psw(npsw), .act_psw(act_psw),
		.act_ebase(act_ebase), .to_host_q(to_host_q));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic mv(input logic w, input logic [4:0] i, g,
		input logic [31:0] d);
		@(negedge core_clk);
		move_req <= '{1'b1, w, '{i, g}, d};
		@(negedge core_clk);
		move_req.valid <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] i, g, input logic [31:0] e,
		input logic err);
		mv(1'b0, i, g, 32'h0);
		chk("error flag", {31'h0, move_err_q}, {31'h0, err});
		if (!err) chk("read data", move_rdata_q, e);
	endtask
	task automatic sweep(input logic gb);
		for (int s = 0; s < bsr_pkg::NREG; s++) begin
			rd(bsr_pkg::ORIG_NUM[s].idx, bsr_pkg::ORIG_NUM[s].grp,
				ev[gb][s], 1'b0);
			rd(bsr_pkg::ALT_IDX[s], bsr_pkg::ALT_GROUP, ev[1][s], gb);
		end
		chk("mode", {31'h0, guest_mode_q}, {31'h0, gb});
		chk("psw view", act_psw, ev[gb][4]);
		chk("base view", act_ebase, ev[gb][11]);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		{resetn, guest_mode_set, host_return_to_guest, kind} = '0;
		move_req = '0;
		pc = 32'h0;
		seed = 32'h3180;
		error_cnt = 0;
		tests_run = 0;
		for (int s = 0; s < bsr_pkg::NREG; s++) begin
			ev[0][s] = bsr_pkg::RESET_VALUE;
			ev[1][s] = bsr_pkg::RESET_VALUE;
		end
		repeat (6) @(negedge core_clk);
		resetn <= 1'b1;
		sweep(1'b0);
		rd(5'h07, 5'h03, 32'h0, 1'b1);
		for (int s = 0; s < 2 * bsr_pkg::NREG; s++) begin
			seed = nxt(seed);
			ev[s % 2][s / 2] = seed;
			if (s % 2 == 0) mv(1'b1, bsr_pkg::ORIG_NUM[s / 2].idx,
				bsr_pkg::ORIG_NUM[s / 2].grp, seed);
			else mv(1'b1, bsr_pkg::ALT_IDX[s / 2], bsr_pkg::ALT_GROUP, seed);
		end
		sweep(1'b0);
		for (int k = 0; k < 4; k++) begin
			@(negedge core_clk);
			{guest_mode_set, host_return_to_guest} <= (k == 0) ? 2'h2 : 2'h1;
			@(negedge core_clk);
			{guest_mode_set, host_return_to_guest} <= 2'h0;
			if (k > 0) begin
				seed = nxt(seed);
				pc <= seed;
				kind <= k[1:0];
				@(negedge core_clk);
				kind <= 2'h0;
				sp = 0;
				do begin
					@(negedge core_clk);
					sp++;
				end while (!(ei_take || fe_take) && sp < 20);
				if (sp == 20) begin
					error_cnt++;
					break;
				end
				chk("to host", {31'h0, to_host_q}, {31'h0, k != 3});
				b = (k == 3);
				sp = (k == 1) ? 0 : 2;
				ev[b][sp + 1] = ev[1][4];
				ev[b][sp] = seed;
				ev[b][(k == 1) ? 5 : 6] = {16'h0000, seed[15:0]};
				ev[b][4] = ~seed;
			end else begin
				b = 1'b1;
				mv(1'b1, bsr_pkg::ALT_IDX[7], bsr_pkg::ALT_GROUP, ~seed);
				chk("refused write", {31'h0, move_err_q}, 32'h1);
				seed = nxt(seed);
				ev[1][8] = seed;
				mv(1'b1, bsr_pkg::ORIG_NUM[8].idx, bsr_pkg::ORIG_NUM[8].grp,
					seed);
			end
			sweep(b);
		end
		print_verdict();
	end
endmodule
